// [design/ext_irq_and_vector_map.sv]
// Purpose: External pin and pin-change interrupt detection with vector map
// Assumes: One clock; sleep wake handled as level outputs to the power unit
// Notes: Registers over AXI4-Lite, 32-bit words, low byte used
//
// Summary of operation
// - Any reset source makes the core fetch from address 0x0000.
// - External interrupt pin request vectors to 0x0001.
// - Low pin-change group vectors to 0x0002, high group to 0x0003.
// - Watchdog at 0x0004, peripherals in order, serial overflow at 0x0010.
// - Pins configured as outputs still raise requests.
// - Any unmasked low-group pin toggle raises the low group request.
// - Any unmasked high-group pin toggle raises the high group request.
// - One mask register per group selects contributing pins.
// - Pin-change wake works without the I/O clock in any sleep mode.
// - External pin triggers on falling edge, rising edge or low level.
// - Low-level mode keeps requesting while the pin stays low.
// - Edge detection needs the I/O clock and halts with it.
// - Low-level wake works without the I/O clock.
// - Low level removed before start-up ends gives wake without interrupt.
// - Then execution resumes after the sleep, not at the handler.
// - Sense field: 00 low, 01 any change, 10 falling, 11 rising.
// - Flags set on trigger, cleared on handler entry or by writing one.
// - External flag reads zero while level sensing is selected.
// - Pin-change request needs both pin mask bit and group enable.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module ext_irq_and_vector_map #(
	parameter int PC_LOW_N = 8,
	parameter int PC_HIGH_N = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins, seen regardless of port direction
	input wire logic ext_irq_pin,
	input wire logic [PC_LOW_N-1:0] pin_change_low_group,
	input wire logic [PC_HIGH_N-1:0] pin_change_high_group,
	// Core and power unit
	input wire logic io_clk_run,
	input wire logic startup_done,
	input wire logic global_irq_en,
	input wire logic handler_ack,
	input wire irq_pkg::periph_req_t periph_req,
	output irq_pkg::vec_req_t vec_req,
	output logic wake_req,
	// AXI4-Lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	import irq_pkg::*;

	initial begin
		if (PC_LOW_N != PC_LOW_W || PC_HIGH_N != PC_HIGH_W)
			$error("pin group widths must match the register fields");
	end

	// ------------------------------------------------------------
	// Registers and pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] sense_reg;
	logic ext_en_reg, pcl_en_reg, pch_en_reg;
	logic ext_flag_reg, pcl_flag_reg, pch_flag_reg;
	logic [PC_LOW_N-1:0] pc_low_mask_reg;
	logic [PC_HIGH_N-1:0] pc_high_mask_reg;
	logic ext_s, ext_prev_reg;
	logic [PC_LOW_N-1:0] pcl_s, pcl_prev_reg;
	logic [PC_HIGH_N-1:0] pch_s, pch_prev_reg;
	logic asleep_reg;

	pin_sync #(.WIDTH(1)) sync_ext (
		.clk(clk), .sys_rst(sys_rst),
		.async_in(ext_irq_pin), .sync_out(ext_s)
	);
	pin_sync #(.WIDTH(PC_LOW_N)) sync_low (
		.clk(clk), .sys_rst(sys_rst),
		.async_in(pin_change_low_group), .sync_out(pcl_s)
	);
	pin_sync #(.WIDTH(PC_HIGH_N)) sync_high (
		.clk(clk), .sys_rst(sys_rst),
		.async_in(pin_change_high_group), .sync_out(pch_s)
	);

	// ------------------------------------------------------------
	// Detection
	// ------------------------------------------------------------
	logic level_mode, ext_edge, ext_trig, pcl_trig, pch_trig;
	logic ext_level_req;
	assign level_mode = (sense_reg == SENSE_LOW);
	always_comb begin
		case (sense_t'(sense_reg))
			SENSE_ANY: ext_edge = ext_s ^ ext_prev_reg;
			SENSE_FALL: ext_edge = ext_prev_reg & ~ext_s;
			SENSE_RISE: ext_edge = ~ext_prev_reg & ext_s;
			default: ext_edge = 1'b0;
		endcase
	end
	// Edges only while the I/O clock runs
	assign ext_trig = ext_edge & io_clk_run & ~level_mode;
	// Masked toggles, pin direction not considered
	assign pcl_trig = |((pcl_s ^ pcl_prev_reg) & pc_low_mask_reg);
	assign pch_trig = |((pch_s ^ pch_prev_reg) & pc_high_mask_reg);
	// Level request lasts while low, held off until start-up finishes
	assign ext_level_req = level_mode & ~ext_s & ext_en_reg
		& ~asleep_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_prev_reg <= 1'b1;
			pcl_prev_reg <= '1;
			pch_prev_reg <= '1;
		end else begin
			// Tracks the pin in sleep too, so no stale edge on resume
			ext_prev_reg <= ext_s;
			pcl_prev_reg <= pcl_s;
			pch_prev_reg <= pch_s;
		end
	end

	// Sleep tracking: wake request does not need the I/O clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			asleep_reg <= 1'b0;
		else if (!io_clk_run)
			asleep_reg <= 1'b1;
		else if (startup_done)
			asleep_reg <= 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			wake_req <= 1'b0;
		else
			wake_req <= (pcl_trig & pcl_en_reg) | (pch_trig & pch_en_reg)
				| (level_mode & ~ext_s & ext_en_reg);
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic [7:0] aw_addr_reg;
	logic aw_have_reg, w_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_go;
	logic [7:0] wbyte;
	assign wr_go = aw_have_reg & w_have_reg & ~s_bvalid;
	assign wbyte = w_data_reg[7:0];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OKAY;
		end else begin
			s_awready <= ~aw_have_reg & ~(s_awvalid & s_awready);
			s_wready <= ~w_have_reg & ~(s_wvalid & s_wready);
			if (s_awvalid && s_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_wdata;
				w_strb_reg <= s_wstrb;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_bvalid <= 1'b1;
				case (aw_addr_reg)
					OFS_MCU_CTRL, OFS_GLOBAL_MASK, OFS_FLAGS,
					OFS_PC_LOW_MASK, OFS_PC_HIGH_MASK, OFS_STATUS:
						s_bresp <= RESP_OKAY;
					default: s_bresp <= RESP_SLVERR;
				endcase
			end else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	logic wr_low;
	assign wr_low = wr_go & w_strb_reg[0];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sense_reg <= SENSE_LOW;
			ext_en_reg <= 1'b0;
			pcl_en_reg <= 1'b0;
			pch_en_reg <= 1'b0;
			pc_low_mask_reg <= '0;
			pc_high_mask_reg <= '0;
		end else if (wr_low) begin
			case (aw_addr_reg)
				OFS_MCU_CTRL:
					sense_reg <= wbyte[SENSE_HI_BIT:SENSE_LO_BIT];
				OFS_GLOBAL_MASK: begin
					ext_en_reg <= wbyte[EXT_BIT];
					pch_en_reg <= wbyte[PCH_BIT];
					pcl_en_reg <= wbyte[PCL_BIT];
				end
				OFS_PC_LOW_MASK: pc_low_mask_reg <= wbyte[PC_LOW_N-1:0];
				OFS_PC_HIGH_MASK: pc_high_mask_reg <= wbyte[PC_HIGH_N-1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flags: set wins over any clear
	// ------------------------------------------------------------
	logic flag_wr;
	logic [VEC_W-1:0] sel_vec;
	assign flag_wr = wr_low & (aw_addr_reg == OFS_FLAGS);
	logic ack_ext, ack_pcl, ack_pch;
	assign ack_ext = handler_ack & vec_req.valid & (vec_req.addr == VEC_EXT);
	assign ack_pcl = handler_ack & vec_req.valid
		& (vec_req.addr == VEC_PC_LOW);
	assign ack_pch = handler_ack & vec_req.valid
		& (vec_req.addr == VEC_PC_HIGH);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_flag_reg <= 1'b0;
			pcl_flag_reg <= 1'b0;
			pch_flag_reg <= 1'b0;
		end else begin
			if (ext_trig)
				ext_flag_reg <= 1'b1;
			else if (level_mode || ack_ext || (flag_wr && wbyte[EXT_BIT]))
				ext_flag_reg <= 1'b0;
			if (pcl_trig)
				pcl_flag_reg <= 1'b1;
			else if (ack_pcl || (flag_wr && wbyte[PCL_BIT]))
				pcl_flag_reg <= 1'b0;
			if (pch_trig)
				pch_flag_reg <= 1'b1;
			else if (ack_pch || (flag_wr && wbyte[PCH_BIT]))
				pch_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb begin
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		case (s_araddr)
			OFS_MCU_CTRL: rd_byte[SENSE_HI_BIT:SENSE_LO_BIT] = sense_reg;
			OFS_GLOBAL_MASK: begin
				rd_byte[EXT_BIT] = ext_en_reg;
				rd_byte[PCH_BIT] = pch_en_reg;
				rd_byte[PCL_BIT] = pcl_en_reg;
			end
			OFS_FLAGS: begin
				rd_byte[EXT_BIT] = ext_flag_reg & ~level_mode;
				rd_byte[PCH_BIT] = pch_flag_reg;
				rd_byte[PCL_BIT] = pcl_flag_reg;
			end
			OFS_PC_LOW_MASK: rd_byte[PC_LOW_N-1:0] = pc_low_mask_reg;
			OFS_PC_HIGH_MASK: rd_byte[PC_HIGH_N-1:0] = pc_high_mask_reg;
			OFS_STATUS: begin
				rd_byte[0] = ext_s;
				rd_byte[1] = asleep_reg;
				rd_byte[2] = wake_req;
			end
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= RESP_OKAY;
		end else begin
			s_arready <= ~s_rvalid & ~(s_arvalid & s_arready);
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rdata <= {24'h000000, rd_byte};
				s_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_rvalid && s_rready)
				s_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Vector selection: lowest address first
	// ------------------------------------------------------------
	logic [NUM_SRC-1:0] pend;
	always_comb begin
		pend = periph_req.periph;
		pend[0] = (ext_flag_reg & ext_en_reg) | ext_level_req;
		pend[1] = pcl_flag_reg & pcl_en_reg;
		pend[2] = pch_flag_reg & pch_en_reg;
		sel_vec = VEC_RESET;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pend[i])
				sel_vec = VEC_EXT + VEC_W'(i);
		end
	end

	// Vector held off after reset; core starts at the reset vector
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			vec_req <= '{valid: 1'b0, addr: VEC_RESET};
		end else begin
			vec_req.valid <= global_irq_en & (|pend) & ~handler_ack;
			vec_req.addr <= (|pend) ? sel_vec : VEC_RESET;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	reset_vec_a: assert property (@(posedge clk) $fell(sys_rst)
		|-> vec_req.addr == VEC_RESET && !vec_req.valid)
		else $error("reset vector not zero");
	ext_vec_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ext_flag_reg && ext_en_reg && global_irq_en && !handler_ack)
		|=> vec_req.valid && vec_req.addr == VEC_EXT)
		else $error("external request not vectored to one");
	pc_vec_a: assert property (@(posedge clk) disable iff (sys_rst)
		(pcl_flag_reg && pcl_en_reg && !pend[0])
		|=> vec_req.addr == VEC_PC_LOW)
		else $error("low group vector wrong");
	last_vec_a: assert property (@(posedge clk) disable iff (sys_rst)
		(pend == 16'h8000) |=> vec_req.addr == VEC_LAST)
		else $error("last peripheral vector wrong");
	pcl_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		((pcl_s ^ pcl_prev_reg) & pc_low_mask_reg) != 0
		|=> pcl_flag_reg)
		else $error("unmasked low toggle missed");
	pch_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!pch_flag_reg && pc_high_mask_reg == 4'h0 && !flag_wr)
		|=> !pch_flag_reg)
		else $error("masked high group raised flag");
	level_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(level_mode && !ext_s && ext_en_reg && !asleep_reg
		&& global_irq_en && !handler_ack) |=> vec_req.valid)
		else $error("level request not held");
	edge_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!io_clk_run && !ext_flag_reg) |=> !ext_flag_reg)
		else $error("edge seen without io clock");
	level_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		level_mode[*2] |-> !ext_flag_reg)
		else $error("flag set in level mode");
	sense_dec_a: assert property (@(posedge clk) disable iff (sys_rst)
		(sense_reg == SENSE_FALL && io_clk_run && ext_prev_reg && !ext_s)
		|=> ext_flag_reg)
		else $error("falling edge not flagged");
	wake_lvl_a: assert property (@(posedge clk) disable iff (sys_rst)
		(level_mode && !ext_s && ext_en_reg) |=> wake_req)
		else $error("level wake missed");
	early_rm_a: assert property (@(posedge clk) disable iff (sys_rst)
		(asleep_reg && !pend[0] && pend[2:1] == 2'b00
		&& periph_req.periph == 16'h0000) |=> !vec_req.valid)
		else $error("interrupt after early level removal");
	flag_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ack_pch && !pch_trig) |=> !pch_flag_reg)
		else $error("handler entry did not clear flag");
	grp_en_a: assert property (@(posedge clk) disable iff (sys_rst)
		!pcl_en_reg |-> !pend[1])
		else $error("group enable ignored");
endmodule // ext_irq_and_vector_map

// [design/irq_pkg.sv]
// Purpose: Shared constants and types for the external interrupt and vector block
// Assumes: 32-bit AXI4-Lite register access, one 100 MHz clock
// Notes: Vector addresses are word addresses into program memory
package irq_pkg;
	localparam int VEC_W = 16;
	localparam int NUM_SRC = 16;
	localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
	localparam logic [VEC_W-1:0] VEC_EXT = 16'h0001;
	localparam logic [VEC_W-1:0] VEC_PC_LOW = 16'h0002;
	localparam logic [VEC_W-1:0] VEC_PC_HIGH = 16'h0003;
	localparam logic [VEC_W-1:0] VEC_WDT = 16'h0004;
	localparam logic [VEC_W-1:0] VEC_LAST = 16'h0010;
	// Register byte offsets
	localparam logic [7:0] OFS_MCU_CTRL = 8'h00;
	localparam logic [7:0] OFS_GLOBAL_MASK = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_PC_LOW_MASK = 8'h0c;
	localparam logic [7:0] OFS_PC_HIGH_MASK = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// Field positions
	localparam int SENSE_LO_BIT = 0;
	localparam int SENSE_HI_BIT = 1;
	localparam int EXT_BIT = 6;
	localparam int PCH_BIT = 5;
	localparam int PCL_BIT = 4;
	localparam int PC_LOW_W = 8;
	localparam int PC_HIGH_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [7:0] REG_RESET = 8'h00;
	typedef enum logic [1:0] {
		SENSE_LOW = 2'b00,
		SENSE_ANY = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} sense_t;
	typedef struct packed {
		logic valid;
		logic [VEC_W-1:0] addr;
	} vec_req_t;
	typedef struct packed {
		logic [NUM_SRC-1:0] periph;
	} periph_req_t;
endpackage

// [design/pin_sync.sv]
// Purpose: Two-stage synchroniser for a group of pins
// Assumes: Inputs are asynchronous to clk
// Notes: Stage one is read only by stage two
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage_reg <= '1;
			sync_out <= '1;
		end else begin
			stage_reg <= async_in;
			sync_out <= stage_reg;
		end
	end
endmodule // pin_sync

// [tb/core_model.sv]
// Purpose: Core sequencer model that enters the handler for a vector
// Assumes: vec_req is registered and drops once its flag is served
// Notes: DELAY sets how many cycles the core takes to answer
`timescale 1ns/100ps
module core_model #(
	parameter int DELAY = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Core side
	input wire logic ack_en,
	input wire irq_pkg::vec_req_t vec_req,
	output logic handler_ack
);
	import irq_pkg::*;
	int wait_cnt;
	// Single-cycle handler entry after DELAY cycles of a pending request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			handler_ack <= 1'b0;
			wait_cnt <= 0;
		end else begin
			handler_ack <= 1'b0;
			if (ack_en && vec_req.valid && !handler_ack) begin
				if (wait_cnt >= DELAY) begin
					handler_ack <= 1'b1;
					wait_cnt <= 0;
				end else begin
					wait_cnt <= wait_cnt + 1;
				end
			end else begin
				wait_cnt <= 0;
			end
		end
	end
endmodule // core_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the interrupt and vector block
// Assumes: Registers over AXI4-Lite, core modelled by core_model
// Notes: Sleep is io_clk_run low, wake completes with startup_done
`timescale 1ns/100ps
module tb;
	import irq_pkg::*;
	logic clk = 0, sys_rst = 1, ext_irq_pin = 1, io_clk_run = 1;
	logic startup_done = 1, global_irq_en = 1, handler_ack, ack_en = 0;
	logic [7:0] pcl = 8'hff, s_awaddr = 0, s_araddr = 0;
	logic [3:0] pch = 4'hf, s_wstrb = 0;
	logic s_awvalid = 0, s_awready, s_wvalid = 0, s_wready, s_bvalid;
	logic s_bready = 0, s_arvalid = 0, s_arready, s_rvalid, s_rready = 0;
	logic [31:0] s_wdata = 0, s_rdata, d;
	logic [1:0] s_bresp, s_rresp, r;
	logic wake_req;
	periph_req_t periph_req = '0;
	vec_req_t vec_req;
	int n_mismatch = 0, check_count = 0;
	always #5 clk = ~clk;
	ext_irq_and_vector_map ext_irq_and_vector_map_i (.clk(clk),
		.sys_rst(sys_rst), .ext_irq_pin(ext_irq_pin),
		.pin_change_low_group(pcl), .pin_change_high_group(pch),
		.io_clk_run(io_clk_run), .startup_done(startup_done),
		.global_irq_en(global_irq_en), .handler_ack(handler_ack),
		.periph_req(periph_req), .vec_req(vec_req), .wake_req(wake_req),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready));
	core_model core_model_i (.clk(clk), .sys_rst(sys_rst), .ack_en(ack_en),
		.vec_req(vec_req), .handler_ack(handler_ack));
	// ----------------------------------------
	// Common tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		s_awaddr <= a; s_awvalid <= 1; s_wdata <= v; s_wstrb <= 4'hf;
		s_wvalid <= 1; s_bready <= 1; n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_awvalid && s_awready) s_awvalid <= 0;
			if (s_wvalid && s_wready) s_wvalid <= 0;
		end while (!(s_bvalid === 1'b1) && n < 50);
		s_bready <= 0; r = s_bresp;
		if (n >= 50) chk(n, 0);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		s_araddr <= a; s_arvalid <= 1; s_rready <= 1; n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_arvalid && s_arready) s_arvalid <= 0;
		end while (!(s_rvalid === 1'b1) && n < 50);
		s_rready <= 0; d = s_rdata; r = s_rresp;
		if (n >= 50) chk(n, 0);
	endtask
	task automatic expect_vec(input logic ex, input logic [15:0] a);
		logic seen;
		logic [15:0] got;
		seen = 0; got = 0;
		repeat (12) begin
			@(posedge clk);
			if (vec_req.valid === 1'b1 && !seen) begin
				seen = 1; got = vec_req.addr;
			end
		end
		chk(seen, ex);
		if (ex) chk(got, a);
	endtask
	task automatic wait_wake();
		int n;
		for (n = 0; n < 12 && wake_req !== 1'b1; n++) @(posedge clk);
		chk(wake_req, 1);
	endtask
	task automatic sleep();
		@(posedge clk);
		io_clk_run <= 0; startup_done <= 0;
	endtask
	task automatic wake();
		@(posedge clk);
		io_clk_run <= 1; startup_done <= 1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		chk(vec_req, 0);
		wr(OFS_MCU_CTRL, 32'h3); rd(OFS_MCU_CTRL);
		chk(d, 32'h3);
		wr(8'h20, 32'h1); chk(r, RESP_SLVERR);
		rd(8'h20); chk(r, RESP_SLVERR);
	endtask
	task automatic t_pc();
		ack_en <= 1;
		wr(OFS_PC_LOW_MASK, 32'h04); wr(OFS_GLOBAL_MASK, 32'h10);
		pcl[0] <= ~pcl[0]; expect_vec(0, 0);
		pcl[2] <= ~pcl[2]; expect_vec(1, VEC_PC_LOW);
		wr(OFS_PC_HIGH_MASK, 32'h8); wr(OFS_GLOBAL_MASK, 32'h20);
		pcl[2] <= ~pcl[2]; expect_vec(0, 0);
		pch[3] <= ~pch[3]; expect_vec(1, VEC_PC_HIGH);
		sleep(); pch[3] <= ~pch[3]; wait_wake();
		wake(); expect_vec(1, VEC_PC_HIGH);
		wr(OFS_FLAGS, 32'h70);
	endtask
	task automatic t_ext();
		logic [1:0] m;
		wr(OFS_GLOBAL_MASK, 32'h40);
		for (m = 2'd1; m != 2'd0; m++) begin
			wr(OFS_MCU_CTRL, {30'h0, m});
			ext_irq_pin <= 0; expect_vec(m != 2'd3, VEC_EXT);
			ext_irq_pin <= 1; expect_vec(m != 2'd2, VEC_EXT);
		end
		wr(OFS_MCU_CTRL, 32'h2); sleep();
		ext_irq_pin <= 0; expect_vec(0, 0);
		ext_irq_pin <= 1; wake(); expect_vec(0, 0);
	endtask
	task automatic t_level();
		wr(OFS_MCU_CTRL, 32'h0);
		ext_irq_pin <= 0; expect_vec(1, VEC_EXT);
		expect_vec(1, VEC_EXT);
		rd(OFS_FLAGS); chk(d[EXT_BIT], 0);
		ext_irq_pin <= 1; repeat (6) @(posedge clk);
		expect_vec(0, 0);
		sleep(); ext_irq_pin <= 0; wait_wake();
		ext_irq_pin <= 1; repeat (6) @(posedge clk);
		wake(); expect_vec(0, 0);
		// Source holds the level through start-up
		sleep(); ext_irq_pin <= 0; wait_wake();
		wake(); expect_vec(1, VEC_EXT);
		ext_irq_pin <= 1; repeat (6) @(posedge clk);
	endtask
	task automatic t_prio();
		ack_en <= 0;
		wr(OFS_MCU_CTRL, 32'h2); wr(OFS_GLOBAL_MASK, 32'h50);
		wr(OFS_FLAGS, 32'h70);
		ext_irq_pin <= 0; pcl[2] <= ~pcl[2]; repeat (10) @(posedge clk);
		chk(vec_req, {1'b1, VEC_EXT});
		wr(OFS_FLAGS, 32'h40); repeat (4) @(posedge clk);
		chk(vec_req, {1'b1, VEC_PC_LOW});
		ack_en <= 1; repeat (10) @(posedge clk);
		chk(vec_req.valid, 0);
		ext_irq_pin <= 1; ack_en <= 0;
		wr(OFS_GLOBAL_MASK, 32'h0);
		periph_req <= 16'h8008; repeat (4) @(posedge clk);
		chk(vec_req, {1'b1, VEC_WDT});
		periph_req <= 16'h8000; repeat (4) @(posedge clk);
		chk(vec_req, {1'b1, VEC_LAST});
		periph_req <= 16'h0; repeat (4) @(posedge clk);
		chk(vec_req.valid, 0);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		t_regs();
		t_pc();
		t_ext();
		t_level();
		t_prio();
		close_out();
	end
	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end
endmodule // tb
